// ### hw/fpg_pkg.sv
// Package with the shared constants of the flash program/erase guard
package fpg_pkg;
    // ****************************************************
    // Geometry
    // ****************************************************
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int FLASH_BYTES = 15360;
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_W = 9;
    localparam logic [ADDR_W-1:0] LOCK_ADDR = 14'h3BFF;
    localparam logic [ADDR_W-1:0] RESERVED_BASE = 14'h3C00;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] UNLOCKED_VAL = 8'hFF;

    // ****************************************************
    // Unlock key register
    // ****************************************************
    localparam logic [7:0] KEY_REG_IDX = 8'hB7;
    localparam logic [DATA_W-1:0] KEY_FIRST = 8'hA5;
    localparam logic [DATA_W-1:0] KEY_SECOND = 8'hF1;

    // ****************************************************
    // Core register map (APB, byte addresses)
    // ****************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_KEY = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_CMD = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_RDATA = 8'h18;
    localparam int CTRL_WE_BIT = 0;
    localparam int CTRL_EE_BIT = 1;
    localparam int CTRL_DBG_BIT = 2;
    localparam logic [2:0] CMD_STORE = 3'h1;
    localparam logic [2:0] CMD_CODE_RD = 3'h2;
    localparam logic [2:0] CMD_EXTERNAL_DATA_RAM_RD = 3'h3;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_LOCKED_BIT = 2;

    // Operation codes on the link
    typedef enum logic [1:0] {
        FPG_OP_STORE = 2'h0,
        FPG_OP_CODE_RD = 2'h1,
        FPG_OP_EXTERNAL_DATA_RAM_RD = 2'h2,
        FPG_OP_KEY_WR = 2'h3
    } fpg_op_t;
endpackage

// ### hw/fpg_link_if.sv
// Interface between core-side controller and the flash guard
`timescale 1ns/1ps
interface fpg_link_if;
    logic req;
    fpg_pkg::fpg_op_t op;
    logic [fpg_pkg::ADDR_W-1:0] addr;
    logic [fpg_pkg::DATA_W-1:0] wdata;
    logic write_en;
    logic erase_en;
    logic debug;
    logic ack;
    logic refused;
    logic [fpg_pkg::DATA_W-1:0] rdata;
    logic locked;

    modport dev (
        input req, op, addr, wdata, write_en, erase_en, debug,
        output ack, refused, rdata, locked
    );
    modport core (
        output req, op, addr, wdata, write_en, erase_en, debug,
        input ack, refused, rdata, locked
    );
endinterface

// ### hw/fpg_key_seq.sv
// Two-value unlock key sequencer
`timescale 1ns/1ps
module fpg_key_seq (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic key_wr,
    input wire logic [fpg_pkg::DATA_W-1:0] key_val,
    input wire logic consume,
    output logic armed
);
    logic first_r;

    // First key seen; any wrong value or a consuming access restarts
    always_ff @(posedge core_clk) begin
        if (rst || consume) begin
            first_r <= 1'b0;
        end else if (key_wr) begin
            first_r <= (key_val == fpg_pkg::KEY_FIRST) && !first_r;
        end
    end

    // Armed only after the ordered pair; one store consumes it
    always_ff @(posedge core_clk) begin
        if (rst || consume) begin
            armed <= 1'b0;
        end else if (key_wr) begin
            armed <= first_r && (key_val == fpg_pkg::KEY_SECOND);
        end
    end
endmodule

// ### hw/fpg_flash_guard.sv
// Device end: flash array with program/erase guard and lock byte
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Programming only clears bits to zero
// - Erase sets every page byte to ones
// - Modify needs key 0xA5 then 0xF1
// - One key pair permits one byte program
// - One key pair permits one page erase
// - Store with both enables erases whole page
// - No modification without write enable
// - Erase needs write and erase enables
// - Byte program: write enable, erase cleared
// - Firmware checks byte erased before programming
// - Firmware masks interrupts around sequence
// - Stores write flash, code reads read it
// - External data reads always hit data RAM
// - Lock byte is last user byte
// - Non-0xFF lock byte locks all pages; reset sets the lock mirror to 0xFF, whatever the byte holds
// - Lock covers the lock byte's page
// - Erase blocked for reserved and lock page
// - Writes blocked into reserved area
// - Protection differs by access method
module fpg_flash_guard #(
    parameter int EXTERNAL_DATA_RAM_BYTES = 512
) (
    input wire logic core_clk,
    input wire logic rst,
    fpg_link_if.dev lnk
);
    localparam int XW = $clog2(EXTERNAL_DATA_RAM_BYTES);
    localparam int PAGES = fpg_pkg::FLASH_BYTES / fpg_pkg::PAGE_BYTES;

    // Data RAM size must be a power of two that the address can reach
    if (EXTERNAL_DATA_RAM_BYTES < 2 || EXTERNAL_DATA_RAM_BYTES > 2 ** fpg_pkg::ADDR_W
        || (EXTERNAL_DATA_RAM_BYTES & (EXTERNAL_DATA_RAM_BYTES - 1)) != 0) begin : g_bad_external_data_ram
        $error("fpg_flash_guard: EXTERNAL_DATA_RAM_BYTES out of range");
    end

    typedef enum logic [2:0] {
        FPG_IDLE = 3'b001,
        FPG_ERASE = 3'b010,
        FPG_DONE = 3'b100
    } fpg_state_t;

    logic [fpg_pkg::DATA_W-1:0] flash_mem [fpg_pkg::FLASH_BYTES];
    logic [fpg_pkg::DATA_W-1:0] external_data_ram_mem [EXTERNAL_DATA_RAM_BYTES];
    fpg_state_t state_r;
    logic [fpg_pkg::PAGE_W-1:0] erase_cnt_r;
    logic [fpg_pkg::ADDR_W-1:0] erase_base_r;
    logic [fpg_pkg::DATA_W-1:0] lock_val_r;
    logic armed;
    logic key_wr;
    logic consume;
    logic idle_req;
    logic in_flash;
    logic is_reserved;
    logic is_lock_page;
    logic sec_locked;
    logic prog_ok;
    logic erase_ok;
    logic restricted;
    logic [fpg_pkg::ADDR_W-1:0] page_base;

    assign idle_req = lnk.req && (state_r == FPG_IDLE);
    assign key_wr = idle_req && (lnk.op == fpg_pkg::FPG_OP_KEY_WR);
    assign in_flash = lnk.addr < fpg_pkg::ADDR_W'(fpg_pkg::FLASH_BYTES);
    assign page_base = {lnk.addr[fpg_pkg::ADDR_W-1:fpg_pkg::PAGE_W], {fpg_pkg::PAGE_W{1'b0}}};
    // Reserved area lies above user space, holding no storage here
    assign is_reserved = lnk.addr >= fpg_pkg::RESERVED_BASE;
    assign is_lock_page = page_base == {fpg_pkg::LOCK_ADDR[fpg_pkg::ADDR_W-1:fpg_pkg::PAGE_W],
                                        {fpg_pkg::PAGE_W{1'b0}}};
    assign sec_locked = lock_val_r != fpg_pkg::UNLOCKED_VAL;
    // Firmware is trusted for its own pages; debug port is restricted while locked
    assign restricted = lnk.debug && sec_locked;
    // Every store consumes the unlock, accepted or not
    assign consume = idle_req && (lnk.op == fpg_pkg::FPG_OP_STORE);
    assign prog_ok = armed && lnk.write_en && !lnk.erase_en && in_flash && !restricted;
    assign erase_ok = armed && lnk.write_en && lnk.erase_en && in_flash && !restricted
                      && !is_lock_page && !is_reserved;

    fpg_key_seq u_key (
        .core_clk(core_clk),
        .rst(rst),
        .key_wr(key_wr),
        .key_val(lnk.wdata),
        .consume(consume),
        .armed(armed)
    );

    // Lock byte mirror, kept current when the last user byte changes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_val_r <= fpg_pkg::UNLOCKED_VAL;
        end else if (consume && prog_ok && lnk.addr == fpg_pkg::LOCK_ADDR) begin
            lock_val_r <= lock_val_r & lnk.wdata;
        end else if (state_r == FPG_ERASE && erase_base_r == fpg_pkg::LOCK_ADDR) begin
            lock_val_r <= fpg_pkg::ERASED_BYTE;
        end
    end

    // Sequencer: one link answer per request, erase walks the page
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= FPG_IDLE;
            erase_cnt_r <= '0;
            erase_base_r <= '0;
        end else begin
            case (state_r)
                FPG_IDLE: begin
                    if (consume && erase_ok) begin
                        state_r <= FPG_ERASE;
                        erase_base_r <= page_base;
                        erase_cnt_r <= '0;
                    end else if (lnk.req) begin
                        state_r <= FPG_DONE;
                    end
                end
                FPG_ERASE: begin
                    erase_cnt_r <= erase_cnt_r + 1'b1;
                    erase_base_r <= erase_base_r + 1'b1;
                    if (erase_cnt_r == fpg_pkg::PAGE_W'(fpg_pkg::PAGE_BYTES - 1)) begin
                        state_r <= FPG_DONE;
                    end
                end
                FPG_DONE: state_r <= FPG_IDLE;
                default: state_r <= FPG_IDLE;
            endcase
        end
    end

    // Flash array: program ANDs, erase fills ones
    always_ff @(posedge core_clk) begin
        if (state_r == FPG_ERASE) begin
            flash_mem[erase_base_r] <= fpg_pkg::ERASED_BYTE;
        end else if (consume && prog_ok) begin
            flash_mem[lnk.addr] <= flash_mem[lnk.addr] & lnk.wdata;
        end
    end

    // Data RAM takes stores without write enable; its reads never go to flash
    always_ff @(posedge core_clk) begin
        if (consume && !lnk.write_en) begin
            external_data_ram_mem[lnk.addr[XW-1:0]] <= lnk.wdata;
        end
    end

    // Answer, read data and refusal flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lnk.ack <= 1'b0;
            lnk.refused <= 1'b0;
            lnk.rdata <= '0;
        end else begin
            lnk.ack <= 1'b0;
            if (idle_req) begin
                lnk.ack <= (state_r == FPG_IDLE) && !(consume && erase_ok);
                lnk.refused <= 1'b0;
                case (lnk.op)
                    fpg_pkg::FPG_OP_STORE: begin
                        lnk.refused <= lnk.write_en && !prog_ok && !erase_ok;
                    end
                    fpg_pkg::FPG_OP_CODE_RD: begin
                        if (restricted || !in_flash) begin
                            lnk.refused <= 1'b1;
                            lnk.rdata <= '0;
                        end else begin
                            lnk.rdata <= flash_mem[lnk.addr];
                        end
                    end
                    fpg_pkg::FPG_OP_EXTERNAL_DATA_RAM_RD: begin
                        lnk.rdata <= external_data_ram_mem[lnk.addr[XW-1:0]];
                    end
                    default: lnk.refused <= 1'b0;
                endcase
            end else if (state_r == FPG_ERASE
                         && erase_cnt_r == fpg_pkg::PAGE_W'(fpg_pkg::PAGE_BYTES - 1)) begin
                lnk.ack <= 1'b1;
            end
        end
    end

    // Lock state visible to the controller
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lnk.locked <= 1'b0;
        end else begin
            lnk.locked <= sec_locked;
        end
    end

    // Page count sanity for this geometry
    if (PAGES * fpg_pkg::PAGE_BYTES != fpg_pkg::FLASH_BYTES) begin : g_bad_pages
        $error("fpg_flash_guard: flash size not whole pages");
    end
endmodule

// ### hw/fpg_core_ctrl.sv
// Core end: APB register block that issues firmware flash requests
`timescale 1ns/1ps
module fpg_core_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fpg_link_if.core lnk
);
    logic [2:0] ctrl_r;
    logic [fpg_pkg::ADDR_W-1:0] addr_r;
    logic [fpg_pkg::DATA_W-1:0] data_r;
    logic busy_r;
    logic refused_r;
    logic [fpg_pkg::DATA_W-1:0] rdata_r;
    logic wr_acc;
    logic start;
    logic mapped;
    logic [31:0] rd_mux;

    assign wr_acc = psel && penable && pwrite && !pready;
    assign start = wr_acc && !busy_r && (paddr == fpg_pkg::REG_KEY || paddr == fpg_pkg::REG_CMD);
    assign mapped = paddr == fpg_pkg::REG_CTRL || paddr == fpg_pkg::REG_KEY
                    || paddr == fpg_pkg::REG_ADDR || paddr == fpg_pkg::REG_DATA
                    || paddr == fpg_pkg::REG_CMD || paddr == fpg_pkg::REG_STAT
                    || paddr == fpg_pkg::REG_RDATA;

    // Read mux
    always_comb begin
        rd_mux = '0;
        case (paddr)
            fpg_pkg::REG_CTRL: rd_mux[2:0] = ctrl_r;
            fpg_pkg::REG_ADDR: rd_mux[fpg_pkg::ADDR_W-1:0] = addr_r;
            fpg_pkg::REG_DATA: rd_mux[fpg_pkg::DATA_W-1:0] = data_r;
            fpg_pkg::REG_STAT: rd_mux[2:0] = {lnk.locked, refused_r, busy_r};
            fpg_pkg::REG_RDATA: rd_mux[fpg_pkg::DATA_W-1:0] = rdata_r;
            default: rd_mux = '0;
        endcase
    end

    // APB answer one cycle into the access phase; busy link refuses a start
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (!mapped || (busy_r
                       && pwrite && (paddr == fpg_pkg::REG_KEY || paddr == fpg_pkg::REG_CMD)));
            prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : '0;
        end
    end

    // Firmware-owned settings
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= '0;
            addr_r <= '0;
            data_r <= '0;
        end else if (wr_acc) begin
            case (paddr)
                fpg_pkg::REG_CTRL: ctrl_r <= pwdata[2:0];
                fpg_pkg::REG_ADDR: addr_r <= pwdata[fpg_pkg::ADDR_W-1:0];
                fpg_pkg::REG_DATA: data_r <= pwdata[fpg_pkg::DATA_W-1:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Link request pulsed for one cycle; busy held until acknowledged
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            lnk.req <= 1'b0;
            lnk.op <= fpg_pkg::FPG_OP_KEY_WR;
            lnk.addr <= '0;
            lnk.wdata <= '0;
        end else if (start) begin
            busy_r <= 1'b1;
            lnk.req <= 1'b1;
            lnk.addr <= addr_r;
            if (paddr == fpg_pkg::REG_KEY) begin
                lnk.op <= fpg_pkg::FPG_OP_KEY_WR;
                lnk.wdata <= pwdata[fpg_pkg::DATA_W-1:0];
            end else begin
                lnk.wdata <= data_r;
                case (pwdata[2:0])
                    fpg_pkg::CMD_CODE_RD: lnk.op <= fpg_pkg::FPG_OP_CODE_RD;
                    fpg_pkg::CMD_EXTERNAL_DATA_RAM_RD: lnk.op <= fpg_pkg::FPG_OP_EXTERNAL_DATA_RAM_RD;
                    default: lnk.op <= fpg_pkg::FPG_OP_STORE;
                endcase
            end
        end else begin
            lnk.req <= 1'b0;
            if (lnk.ack) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Enables follow the control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lnk.write_en <= 1'b0;
            lnk.erase_en <= 1'b0;
            lnk.debug <= 1'b0;
        end else begin
            lnk.write_en <= ctrl_r[fpg_pkg::CTRL_WE_BIT];
            lnk.erase_en <= ctrl_r[fpg_pkg::CTRL_EE_BIT];
            lnk.debug <= ctrl_r[fpg_pkg::CTRL_DBG_BIT];
        end
    end

    // Result capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            refused_r <= 1'b0;
            rdata_r <= '0;
        end else if (lnk.ack) begin
            refused_r <= lnk.refused;
            rdata_r <= lnk.rdata;
        end
    end
endmodule

// ### test/fpg_link_asserts.sv
// Checker of the link between core controller and flash guard
`timescale 1ns/1ps
module fpg_link_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req,
    input wire fpg_pkg::fpg_op_t op,
    input wire logic [fpg_pkg::ADDR_W-1:0] addr,
    input wire logic [fpg_pkg::DATA_W-1:0] wdata,
    input wire logic write_en,
    input wire logic erase_en,
    input wire logic debug,
    input wire logic ack,
    input wire logic refused,
    input wire logic [fpg_pkg::DATA_W-1:0] rdata,
    input wire logic locked
);
    // ****************************************************
    // Key tracking and properties
    // ****************************************************
    logic [1:0] kst_r;
    logic st_w;
    logic er_w;
    assign st_w = req && op == fpg_pkg::FPG_OP_STORE;
    assign er_w = st_w && write_en && erase_en;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of the unlock state; any store uses up the pair
    always_ff @(posedge core_clk) begin
        if (rst || st_w) begin
            kst_r <= 2'h0;
        end else if (req && op == fpg_pkg::FPG_OP_KEY_WR) begin
            if (wdata == fpg_pkg::KEY_FIRST) kst_r <= 2'h1;
            else if (kst_r == 2'h1 && wdata == fpg_pkg::KEY_SECOND) kst_r <= 2'h2;
            else kst_r <= 2'h0;
        end
    end
    property p_quick; req && !er_w |=> ack; endproperty
    a_quick: assert property (p_quick) else $error("late answer on link");
    // An erase not answered in the cycle after the store must stay quiet 8 cycles from there, then answer within 520
    property p_erase; er_w ##1 !ack |-> (!ack)[*8] ##[1:520] ack; endproperty
    a_erase: assert property (p_erase) else $error("erase answer timing");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    property p_req_pulse; req |=> !req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("req longer than a cycle");
    property p_no_key; st_w && write_en && kst_r != 2'h2 |=> ack && refused; endproperty
    a_no_key: assert property (p_no_key) else $error("store taken without key");
    property p_ram_st; st_w && !write_en |=> ack && !refused; endproperty
    a_ram_st: assert property (p_ram_st) else $error("data RAM store refused");
    property p_ram_rd;
        req && (op == fpg_pkg::FPG_OP_EXTERNAL_DATA_RAM_RD || op == fpg_pkg::FPG_OP_KEY_WR) |=> !refused;
    endproperty
    a_ram_rd: assert property (p_ram_rd) else $error("data RAM read refused");
    property p_lock_pg;
        er_w && addr[13:9] == fpg_pkg::LOCK_ADDR[13:9] |=> ack && refused;
    endproperty
    a_lock_pg: assert property (p_lock_pg) else $error("lock page erased");
    property p_dbg;
        req && debug && locked && op == fpg_pkg::FPG_OP_CODE_RD |=> refused && rdata == 8'h00;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug read of locked flash");
    property p_fw_rd;
        req && !debug && op == fpg_pkg::FPG_OP_CODE_RD && addr < fpg_pkg::RESERVED_BASE
            |=> ack && !refused;
    endproperty
    a_fw_rd: assert property (p_fw_rd) else $error("firmware read refused");
endmodule

// ### test/tb_top.sv
// Testbench: APB master driving the core end of the flash guard link
`timescale 1ns/1ps
module tb_top;
    // ****************************************************
    // Signals, design and checker
    // ****************************************************
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic slv;
    logic ref_f;
    logic [7:0] rb;
    int error_cnt = 0;
    int n_tests = 0;
    fpg_link_if lnk_if();
    fpg_core_ctrl fpg_core_ctrl_i(.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_if.core));
    fpg_flash_guard #(.EXTERNAL_DATA_RAM_BYTES(512)) fpg_flash_guard_i(.core_clk(core_clk), .rst(rst),
        .lnk(lnk_if.dev));
    fpg_link_asserts fpg_link_asserts_i(.core_clk(core_clk), .rst(rst), .req(lnk_if.req),
        .op(lnk_if.op), .addr(lnk_if.addr), .wdata(lnk_if.wdata),
        .write_en(lnk_if.write_en), .erase_en(lnk_if.erase_en), .debug(lnk_if.debug),
        .ack(lnk_if.ack), .refused(lnk_if.refused), .rdata(lnk_if.rdata),
        .locked(lnk_if.locked));
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    // ****************************************************
    // Bus tasks and compares
    // ****************************************************
    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        wr(fpg_pkg::REG_KEY, {24'h0, k1});
        wr(fpg_pkg::REG_KEY, {24'h0, k2});
    endtask
    // Issue a command through the address, data and command registers
    task automatic issue(input logic [2:0] c, input logic [13:0] a, input logic [7:0] d);
        wr(fpg_pkg::REG_ADDR, {18'h0, a});
        wr(fpg_pkg::REG_DATA, {24'h0, d});
        wr(fpg_pkg::REG_CMD, {29'h0, c});
    endtask
    // Poll busy; a hang is left to the watchdog
    task automatic wait_done();
        do begin
            apb(1'b0, fpg_pkg::REG_STAT, 32'h0);
        end while (rd[fpg_pkg::ST_BUSY_BIT] !== 1'b0);
        ref_f = rd[fpg_pkg::ST_REFUSED_BIT];
        apb(1'b0, fpg_pkg::REG_RDATA, 32'h0);
        rb = rd[7:0];
    endtask
    task automatic run(input logic [2:0] c, input logic [13:0] a, input logic [7:0] d);
        issue(c, a, d);
        wait_done();
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        apb(1'b0, fpg_pkg::REG_CTRL, 32'h0);
        chk_byte("ctrl reset", 8'h00, rd[7:0]);
        apb(1'b0, 8'h40, 32'h0);
        chk_bit("unmapped err", 1'b1, slv);
        chk_byte("unmapped data", 8'h00, rd[7:0]);
        $display("test regs done");
    endtask
    // Page erase, busy refusal, and the one-page-per-pair limit
    task automatic t_erase();
        wr(fpg_pkg::REG_CTRL, 32'h3);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        issue(fpg_pkg::CMD_STORE, 14'h0010, 8'h00);
        wr(fpg_pkg::REG_KEY, 32'h0);
        chk_bit("key while busy", 1'b1, slv);
        wait_done();
        chk_bit("erase refused", 1'b0, ref_f);
        run(fpg_pkg::CMD_CODE_RD, 14'h0000, 8'h00);
        chk_byte("page start", fpg_pkg::ERASED_BYTE, rb);
        run(fpg_pkg::CMD_CODE_RD, 14'h01FF, 8'h00);
        chk_byte("page end", fpg_pkg::ERASED_BYTE, rb);
        run(fpg_pkg::CMD_STORE, 14'h0020, 8'h00);
        chk_bit("erase no key", 1'b1, ref_f);
        $display("test erase done");
    endtask
    task automatic t_program();
        wr(fpg_pkg::REG_CTRL, 32'h1);
        run(fpg_pkg::CMD_CODE_RD, 14'h0010, 8'h00);
        chk_byte("erased before prog", fpg_pkg::ERASED_BYTE, rb);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, 14'h0010, 8'hA5);
        chk_bit("prog refused", 1'b0, ref_f);
        run(fpg_pkg::CMD_CODE_RD, 14'h0010, 8'h00);
        chk_byte("prog data", 8'hA5, rb);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, 14'h0010, 8'h5A);
        run(fpg_pkg::CMD_CODE_RD, 14'h0010, 8'h00);
        chk_byte("bits only clear", 8'h00, rb);
        run(fpg_pkg::CMD_STORE, 14'h0020, 8'h00);
        chk_bit("second store", 1'b1, ref_f);
        keys(fpg_pkg::KEY_SECOND, fpg_pkg::KEY_FIRST);
        run(fpg_pkg::CMD_STORE, 14'h0021, 8'h00);
        chk_bit("keys reversed", 1'b1, ref_f);
        run(fpg_pkg::CMD_CODE_RD, 14'h0021, 8'h00);
        chk_byte("reversed byte", fpg_pkg::ERASED_BYTE, rb);
        $display("test program done");
    endtask
    // Stores without write enable, or erase enable alone, go to data RAM
    task automatic t_ram();
        wr(fpg_pkg::REG_CTRL, 32'h0);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, 14'h0030, 8'h3C);
        run(fpg_pkg::CMD_CODE_RD, 14'h0030, 8'h00);
        chk_byte("no write enable", fpg_pkg::ERASED_BYTE, rb);
        wr(fpg_pkg::REG_CTRL, 32'h2);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, 14'h0031, 8'h00);
        run(fpg_pkg::CMD_CODE_RD, 14'h0031, 8'h00);
        chk_byte("erase enable only", fpg_pkg::ERASED_BYTE, rb);
        wr(fpg_pkg::REG_CTRL, 32'h3);
        run(fpg_pkg::CMD_EXTERNAL_DATA_RAM_RD, 14'h0030, 8'h00);
        chk_byte("ram read", 8'h3C, rb);
        $display("test ram done");
    endtask
    task automatic t_lock();
        wr(fpg_pkg::REG_CTRL, 32'h3);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, fpg_pkg::LOCK_ADDR, 8'h00);
        chk_bit("lock page erase", 1'b1, ref_f);
        wr(fpg_pkg::REG_CTRL, 32'h1);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, fpg_pkg::RESERVED_BASE, 8'h00);
        chk_bit("reserved write", 1'b1, ref_f);
        keys(fpg_pkg::KEY_FIRST, fpg_pkg::KEY_SECOND);
        run(fpg_pkg::CMD_STORE, fpg_pkg::LOCK_ADDR, 8'h00);
        apb(1'b0, fpg_pkg::REG_STAT, 32'h0);
        chk_bit("locked", 1'b1, rd[fpg_pkg::ST_LOCKED_BIT]);
        wr(fpg_pkg::REG_CTRL, 32'h4);
        run(fpg_pkg::CMD_CODE_RD, 14'h0000, 8'h00);
        chk_bit("debug read", 1'b1, ref_f);
        chk_byte("debug data", 8'h00, rb);
        run(fpg_pkg::CMD_CODE_RD, fpg_pkg::LOCK_ADDR, 8'h00);
        chk_bit("debug lock page", 1'b1, ref_f);
        wr(fpg_pkg::REG_CTRL, 32'h0);
        run(fpg_pkg::CMD_CODE_RD, 14'h0000, 8'h00);
        chk_byte("firmware read", fpg_pkg::ERASED_BYTE, rb);
        $display("test lock done");
    endtask
    // ****************************************************
    // Sequence, verdict and watchdog
    // ****************************************************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Erase has to come first: the array holds no known value before it
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_erase();
        t_program();
        t_ram();
        t_lock();
        close_out();
    end
    // Whole run is about a thousand cycles
    initial begin
        #(25 * 40000);
        error_cnt++;
        close_out();
    end
endmodule
